// ===== src/voltage_code_tracker.sv
// voltage code tracker: samples the select code, moves the setpoint
// assumes the host keeps its own step size and pacing in direct modes
//
// Contract
// - the response to a new code depends on the active table mode.
// - direct modes sample the code on each one-cycle pulse of an internal 3 MHz strobe.
// - slewing modes sample the code on the same 3 MHz strobe.
// - a new code is taken only after three equal differing reads in a row.
// - direct modes load the setpoint with the new level at once.
// - slewing modes accept code changes of several steps at once.
// - slewing modes step the setpoint by one 6.25 mV step at 330 kHz until equal.
`timescale 1ns/1ps
`include "vtrack_regs.svh"

module voltage_code_tracker #(
    parameter int CODE_W     = `CODE_W,
    parameter int SETPOINT_W = `SETPOINT_W,
    parameter int SAMPLE_DIV = `SAMPLE_DIV,
    parameter int STEP_DIV   = `STEP_DIV
) (
    input  wire logic                  core_clk,   // 25 MHz clock
    input  wire logic                  rst,        // sync reset, high
    input  wire vtrack_pkg::mode_type  mode,       // table mode, static
    input  wire logic [CODE_W-1:0]     code_pin,   // voltage_select_code pins
    output logic [SETPOINT_W-1:0]      setpoint,   // reference in step units
    output logic [CODE_W-1:0]          target,     // accepted code
    output logic                       busy        // slew in progress
);

    // ----------------------------------------
    // sample and step strobes
    // ----------------------------------------
    logic [7:0]  sample_cnt;
    logic [7:0]  step_cnt;
    logic        sample_tick;
    logic        step_tick;

    wire sample_wrap = (sample_cnt == 8'(SAMPLE_DIV - 1));
    wire step_wrap   = (step_cnt == 8'(STEP_DIV - 1));

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            sample_cnt  <= 8'h00;
            sample_tick <= 1'b0;
        end
        else
        begin
            sample_cnt  <= sample_wrap ? 8'h00 : sample_cnt + 8'h01;
            sample_tick <= sample_wrap;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            step_cnt  <= 8'h00;
            step_tick <= 1'b0;
        end
        else
        begin
            step_cnt  <= step_wrap ? 8'h00 : step_cnt + 8'h01;
            step_tick <= step_wrap;
        end
    end

    // ----------------------------------------
    // code filter
    // ----------------------------------------
    logic [CODE_W-1:0] code_valid;
    logic              code_new;

    code_filter #(
        .CODE_W (CODE_W),
        .READS  (`STABLE_READS)
    ) u_code_filter (
        .core_clk    (core_clk),
        .rst         (rst),
        .sample_tick (sample_tick),
        .code_pin    (code_pin),
        .code_valid  (code_valid),
        .code_new    (code_new)
    );

    // ----------------------------------------
    // setpoint control
    // ----------------------------------------
    vtrack_pkg::state_type state;

    wire slew_mode = mode[1];
    wire [SETPOINT_W-1:0] goal = SETPOINT_W'(target);
    wire at_goal   = (setpoint == goal);
    wire go_up     = (setpoint < goal);

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            setpoint <= `SETPOINT_RST;
            target   <= `CODE_RST;
            state    <= vtrack_pkg::st_idle;
        end
        else
        begin
            if (code_new)
                target <= code_valid;
            case (state)
                vtrack_pkg::st_idle:
                begin
                    if (code_new && !slew_mode)
                        setpoint <= SETPOINT_W'(code_valid);
                    else if (code_new)
                        state <= vtrack_pkg::st_slewing;
                end
                vtrack_pkg::st_slewing:
                begin
                    if (!slew_mode)
                    begin
                        setpoint <= goal;
                        state    <= vtrack_pkg::st_idle;
                    end
                    else if (at_goal && !code_new)
                        state <= vtrack_pkg::st_idle;
                    else if (step_tick && !at_goal)
                        setpoint <= go_up ? setpoint + 1'b1
                                          : setpoint - 1'b1;
                end
                default:
                    state <= vtrack_pkg::st_idle;
            endcase
        end
    end

    assign busy = (state == vtrack_pkg::st_slewing);

endmodule // voltage_code_tracker

// ===== src/vtrack_regs.svh
// constants for the voltage code tracker: widths, timing counts, reset values
// assumes core_clk at 25 MHz; included by bare name
`ifndef VTRACK_REGS_SVH
`define VTRACK_REGS_SVH

`define CORE_CLK_HZ        25000000
`define SAMPLE_CLK_HZ      3000000
`define STEP_CLK_HZ        330000
`define SAMPLE_DIV         (`CORE_CLK_HZ / `SAMPLE_CLK_HZ)
`define STEP_DIV           (`CORE_CLK_HZ / `STEP_CLK_HZ)
`define STABLE_READS       3
`define STEP_UV            6250
`define CODE_W             8
`define SETPOINT_W         16
`define SETPOINT_RST       16'h0000
`define CODE_RST           8'h00

`endif

// ===== src/vtrack_pkg.sv
// types for the voltage code tracker
// no assumptions beyond the header
package vtrack_pkg;

    typedef enum logic [1:0]
    {
        mode_direct_a = 2'b00,
        mode_direct_b = 2'b01,
        mode_slew_a   = 2'b10,
        mode_slew_b   = 2'b11
    } mode_type;

    typedef enum logic [1:0]
    {
        st_idle    = 2'b00,
        st_slewing = 2'b01
    } state_type;

    typedef struct packed
    {
        logic [15:0] setpoint;
        logic [7:0]  target;
        logic        busy;
    } status_type;

endpackage

// ===== src/code_filter.sv
// sampler and stability filter for the voltage select code
// assumes a sample strobe on core_clk and a pin input from outside the domain
`timescale 1ns/1ps
`include "vtrack_regs.svh"

module code_filter #(
    parameter int CODE_W = `CODE_W,
    parameter int READS  = `STABLE_READS
) (
    input  wire logic              core_clk,     // clock
    input  wire logic              rst,          // sync reset, high
    input  wire logic              sample_tick,  // one-cycle sample strobe
    input  wire logic [CODE_W-1:0] code_pin,     // raw code pins
    output logic [CODE_W-1:0]      code_valid,   // accepted code
    output logic                   code_new      // pulse on acceptance
);

    // ----------------------------------------
    // three-flop synchroniser
    // ----------------------------------------
    logic [CODE_W-1:0] sync1;
    logic [CODE_W-1:0] sync2;
    logic [CODE_W-1:0] sync3;
    logic [CODE_W-1:0] held;
    logic [CODE_W-1:0] cand;
    logic [1:0]        run;

    // a read only moves once the second and third flops agree
    wire                  agree    = (sync2 == sync3);
    wire [CODE_W-1:0]     rd       = agree ? sync3 : held;
    wire                  differs  = (rd != code_valid);
    wire                  same_run = (rd == cand);
    wire                  hit      = sample_tick && differs && same_run
                                     && (run == 2'(READS - 1));

    always_ff @(posedge core_clk)
    begin
        sync1 <= code_pin;
        sync2 <= sync1;
        sync3 <= sync2;
    end

    // ----------------------------------------
    // consecutive read counter
    // ----------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            cand       <= `CODE_RST;
            run        <= 2'h0;
            held       <= `CODE_RST;
            code_valid <= `CODE_RST;
            code_new   <= 1'b0;
        end
        else
        begin
            code_new <= 1'b0;
            if (agree)
                held <= sync3;
            if (sample_tick)
            begin
                if (!differs)
                    run <= 2'h0;
                else if (!same_run)
                begin
                    cand <= rd;
                    run  <= 2'h1;
                end
                else if (hit)
                begin
                    code_valid <= rd;
                    code_new   <= 1'b1;
                    run        <= 2'h0;
                end
                else
                    run <= run + 2'h1;
            end
        end
    end

endmodule // code_filter

// ===== dv/vct_properties.sv
// assertions on voltage_code_tracker ports
// bound from the bench; mode moves only in reset
`timescale 1ns/1ps
module vct_properties #(parameter int STEP_DIV = 75) (
    input wire logic                 core_clk, // clock
    input wire logic                 rst,      // reset
    input wire vtrack_pkg::mode_type mode,     // mode
    input wire logic [7:0]           code_pin, // pins
    input wire logic [15:0]          setpoint, // level
    input wire logic [7:0]           target,   // code
    input wire logic                 busy      // ramp
);
    localparam int GAP = STEP_DIV - 2;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);
    property p_de; !mode[1] |-> setpoint == {8'h00, target}; endproperty
    a_de: assert property (p_de) else $error("jump");
    property p_dn; !mode[1] |-> !busy; endproperty
    a_dn: assert property (p_dn) else $error("busy");
    property p_ie; !busy |-> setpoint == {8'h00, target}; endproperty
    a_ie: assert property (p_ie) else $error("stop");
    property p_st; mode[1] && $changed(setpoint) |-> setpoint - $past(setpoint) ==
        ($past(setpoint) < {8'h00, $past(target)} ? 16'h0001 : 16'hffff); endproperty
    a_st: assert property (p_st) else $error("step");
    property p_gp; mode[1] && $changed(setpoint) |=>
        !$changed(setpoint) throughout (##GAP 1); endproperty
    a_gp: assert property (p_gp) else $error("rate");
    property p_bm; busy |-> ##[0:STEP_DIV] (!busy || $changed(setpoint)); endproperty
    a_bm: assert property (p_bm) else $error("stall");
    property p_ah; $changed(target) |->
        $past(code_pin, 4) == target && $past(code_pin, 12) == target &&
        $past(code_pin, 20) == target; endproperty
    a_ah: assert property (p_ah) else $error("early");
    property p_ag; $changed(target) |=> $stable(target) throughout (##22 1); endproperty
    a_ag: assert property (p_ag) else $error("fast");
endmodule // vct_properties

// ===== dv/vid_host.sv
// host model driving the voltage select code pins
// assumes the bench paces calls; hold stands in for the 2 ms gap
`timescale 1ns/1ps
module vid_host (
    input  wire logic  core_clk, // clock
    output logic [7:0] code_pin  // code pins
);
    initial code_pin = 8'h00;
    task send(input logic [7:0] code, input int hold);
        @(posedge core_clk);
        code_pin <= code;
        repeat (hold) @(posedge core_clk);
    endtask
endmodule // vid_host

// ===== dv/voltage_code_tracker_test.sv
// bench for voltage_code_tracker with a host model on the pins
// assumes 25 MHz core_clk; mode changes only in reset
`timescale 1ns/1ps
module voltage_code_tracker_test;
    logic                 core_clk = 1'b0;
    logic                 rst, busy;
    logic [7:0]           code_pin, target;
    logic [15:0]          setpoint;
    vtrack_pkg::mode_type mode;
    int                   err_count = 0, num_checks = 0;
    voltage_code_tracker u_voltage_code_tracker (.core_clk(core_clk), .rst(rst), .mode(mode),
        .code_pin(code_pin), .setpoint(setpoint), .target(target), .busy(busy));
    vid_host u_vid_host (.core_clk(core_clk), .code_pin(code_pin));
    initial forever #20 core_clk = ~core_clk;
    initial
    begin
        repeat (5000) @(posedge core_clk);
        err_count++;
        conclude();
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        err_count += int'(got !== exp);
        if (got !== exp)
            $display("ERROR %0t: got %h want %h", $time, got, exp);
    endtask
    task conclude();
        $display("%0d checks %0d errors", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task t_start(input vtrack_pkg::mode_type m);
        rst <= 1'b1;
        mode <= m;
        u_vid_host.send(8'h00, 20);
        rst <= 1'b0;
        @(posedge core_clk);
        chk(setpoint | {target, 7'h00, busy}, 16'h0000);
    endtask
    task s_modes();
        for (int m = 0; m < 4; m++)
        begin
            t_start(vtrack_pkg::mode_type'(m));
            u_vid_host.send(8'h01, 120);
            chk({target, setpoint[7:0]}, 16'h0101);
        end
    endtask
    task s_direct();
        t_start(vtrack_pkg::mode_direct_b);
        for (int i = 1; i < 4; i++)
        begin
            u_vid_host.send(8'(i), 40);
            chk(setpoint, 16'(i));
        end
        u_vid_host.send(8'h04, 10);
        u_vid_host.send(8'h03, 40);
        chk({8'h00, target}, 16'h0003);
    endtask
    task s_slew();
        int n;
        t_start(vtrack_pkg::mode_slew_b);
        u_vid_host.send(8'h06, 0);
        for (n = 0; n < 999 && setpoint !== 16'h0006; n++)
            @(posedge core_clk);
        chk(16'(n > 395 && n < 486), 16'h0001);
        u_vid_host.send(8'h00, 180);
        chk(16'(setpoint > 1 && setpoint < 6), 16'h0001);
        chk({15'h0000, busy}, 16'h0001);
        u_vid_host.send(8'h09, 900);
        chk(setpoint, 16'h0009);
        chk({15'h0000, busy}, 16'h0000);
    endtask
    initial
    begin
        s_modes();
        s_direct();
        s_slew();
        conclude();
    end
endmodule // voltage_code_tracker_test
bind voltage_code_tracker vct_properties #(.STEP_DIV(STEP_DIV)) u_vct_properties (.core_clk(core_clk),
    .rst(rst), .mode(mode), .code_pin(code_pin), .setpoint(setpoint), .target(target), .busy(busy));
